// *** src/trng_pkg.sv ***
package trng_pkg;

  // raw source is sampled once every SAMPLE_CYC clocks
  localparam int unsigned SAMPLE_CYC = 8;
  localparam int unsigned SMP_W      = 3;
  localparam logic [SMP_W-1:0] SMP_LAST = 3'h7;

  // total failure: this many equal raw bits in a row
  localparam int unsigned RUN_W = 6;
  localparam logic [RUN_W-1:0] TOT_RUN_LIMIT = 6'h30;

  // raw bits are delayed this long before use, so a failure
  // is always seen before any bit made after its onset (total failure only; a defect shows at window end)
  localparam int unsigned DLY_LEN = 48;

  // online test: ones counted over a window of raw bits
  localparam int unsigned WIN_W  = 8;
  localparam int unsigned ONES_W = 9;
  localparam logic [WIN_W-1:0]  WIN_LAST = 8'hff;
  localparam logic [ONES_W-1:0] ONES_LO  = 9'h064;
  localparam logic [ONES_W-1:0] ONES_HI  = 9'h09c;

  // output words and buffer
  localparam int unsigned WORD_W     = 16;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned CNT_W      = 5;
  localparam logic [CNT_W-1:0] BITS_8  = 5'h08;
  localparam logic [CNT_W-1:0] BITS_16 = 5'h10;

  // health gate states
  typedef enum logic [2:0] {
    ST_START = 3'b001,
    ST_RUN   = 3'b010,
    ST_FAIL  = 3'b100
  } gate_state_e;

endpackage

// *** src/trng_fifo.sv ***
module trng_fifo
  import trng_pkg::*;
#(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 16
)
(
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic             flush,
  input  wire logic             wr_valid,
  output logic                  wr_ready,
  input  wire logic [WIDTH-1:0] wr_data,
  output logic                  rd_valid,
  input  wire logic             rd_ready,
  output logic      [WIDTH-1:0] rd_data
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];   // storage, never reset
  logic [AW:0]      wr_ptr_r;      // extra bit tells full from empty
  logic [AW:0]      rd_ptr_r;
  logic [AW:0]      wr_ptr_nxt;
  logic [AW:0]      rd_ptr_nxt;
  logic             do_wr;
  logic             do_rd;

  // full when pointers differ only in the wrap bit
  assign wr_ready = (wr_ptr_r != {~rd_ptr_r[AW], rd_ptr_r[AW-1:0]});
  assign rd_valid = (wr_ptr_r != rd_ptr_r);
  assign rd_data  = mem[rd_ptr_r[AW-1:0]];
  assign do_wr    = wr_valid && wr_ready && !flush;
  assign do_rd    = rd_valid && rd_ready && !flush;

  // pointer update; flush drops all stored words at once
  always_comb
  begin
    wr_ptr_nxt = wr_ptr_r;
    rd_ptr_nxt = rd_ptr_r;
    if (flush)
    begin
      wr_ptr_nxt = '0;
      rd_ptr_nxt = '0;
    end
    else
    begin
      if (do_wr)
        wr_ptr_nxt = wr_ptr_r + 1'b1;
      if (do_rd)
        rd_ptr_nxt = rd_ptr_r + 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end
    else
    begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
    end
  end

  // storage write, no reset needed on data
  always_ff @(posedge clock)
  begin
    if (do_wr)
      mem[wr_ptr_r[AW-1:0]] <= wr_data;
  end

endmodule

// *** src/physical_trng_health_gate.sv ***
//Contract
// - raw bits come from physical source
// - startup total failure blocks all output
// - withhold words using bits after failure (code: total failure only; a defect is seen at window end)
// - online test at startup and always
// - no words before startup pass or after defect
// - online test continuous, bounded detection time
// - output words 8 or 16 bits
// - entropy per bit above 0.997; the ones bounds pass down to about 0.965
module physical_trng_health_gate
  import trng_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              resetn,
  input  wire logic              raw_bit,
  input  wire logic              wide16,
  input  wire logic              out_ready,
  output logic      [WORD_W-1:0] out_data,
  output logic                   out_valid,
  output logic                   rng_ok,
  output logic                   fail_sticky,
  output logic                   fail_total,
  output logic                   fail_defect
);

  // reset release synchroniser
  logic rst_s1_r;
  logic rst_n;

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_s1_r <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_n    <= rst_s1_r;
    end
  end

  // raw pin synchroniser and sample divider
  logic             raw_s1_r;   // read only by raw_s2_r
  logic             raw_s2_r;
  logic [SMP_W-1:0] smp_cnt_r;
  logic [SMP_W-1:0] smp_cnt_nxt;
  logic             smp_tick;   // one raw bit taken this cycle

  assign smp_tick = (smp_cnt_r == SMP_LAST);

  // free running: sampling never waits for software
  always_comb
  begin
    smp_cnt_nxt = smp_cnt_r + 1'b1;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      raw_s1_r  <= 1'b0;
      raw_s2_r  <= 1'b0;
      smp_cnt_r <= '0;
    end
    else
    begin
      raw_s1_r  <= raw_bit;
      raw_s2_r  <= raw_s1_r;
      smp_cnt_r <= smp_cnt_nxt;
    end
  end

  // health tests: run length and windowed ones count
  logic              last_bit_r;
  logic [RUN_W-1:0]  run_cnt_r;
  logic [WIN_W-1:0]  win_cnt_r;
  logic [ONES_W-1:0] ones_r;
  logic              last_bit_nxt;
  logic [RUN_W-1:0]  run_cnt_nxt;
  logic [WIN_W-1:0]  win_cnt_nxt;
  logic [ONES_W-1:0] ones_nxt;
  logic [ONES_W-1:0] ones_sum;
  logic              tot_fail_det;  // stuck source seen
  logic              win_end;       // last bit of a window
  logic              defect_det;    // window out of bounds

  assign ones_sum = ones_r + ONES_W'(raw_s2_r);
  assign win_end  = smp_tick && (win_cnt_r == WIN_LAST);
  // the bias bounds pass 100 to 156 ones per 256 bits, down to about 0.965 entropy per bit
  assign defect_det = win_end &&
                      ((ones_sum < ONES_LO) || (ones_sum > ONES_HI));
  assign tot_fail_det = smp_tick && (raw_s2_r == last_bit_r) &&
                        (run_cnt_r == TOT_RUN_LIMIT - 1'b1);

  // both tests run on every sample, in every state
  always_comb
  begin
    last_bit_nxt = last_bit_r;
    run_cnt_nxt  = run_cnt_r;
    win_cnt_nxt  = win_cnt_r;
    ones_nxt     = ones_r;
    if (smp_tick)
    begin
      last_bit_nxt = raw_s2_r;
      // saturate so a long stuck run stays detected
      if (raw_s2_r != last_bit_r)
        run_cnt_nxt = 6'h01;
      else if (run_cnt_r != TOT_RUN_LIMIT)
        run_cnt_nxt = run_cnt_r + 1'b1;
      win_cnt_nxt = win_cnt_r + 1'b1;
      ones_nxt    = win_end ? '0 : ones_sum;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      last_bit_r <= 1'b0;
      run_cnt_r  <= '0;
      win_cnt_r  <= '0;
      ones_r     <= '0;
    end
    else
    begin
      last_bit_r <= last_bit_nxt;
      run_cnt_r  <= run_cnt_nxt;
      win_cnt_r  <= win_cnt_nxt;
      ones_r     <= ones_nxt;
    end
  end

  // gate state machine and failure flags
  gate_state_e state_r;
  gate_state_e state_nxt;
  logic        rng_ok_r;
  logic        fail_r;
  logic        tot_r;
  logic        def_r;
  logic        rng_ok_nxt;
  logic        fail_nxt;
  logic        tot_nxt;
  logic        def_nxt;
  logic        go_fail;   // leave service this cycle

  assign go_fail = (state_r != ST_FAIL) && (tot_fail_det || defect_det);

  // failure is final until reset: a weak source is not retried
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_START:
      begin
        if (go_fail)
          state_nxt = ST_FAIL;
        else if (win_end)
          state_nxt = ST_RUN;
      end
      ST_RUN:
      begin
        if (go_fail)
          state_nxt = ST_FAIL;
      end
      ST_FAIL:
        state_nxt = ST_FAIL;
      default:
        state_nxt = ST_FAIL;
    endcase
    rng_ok_nxt = (state_nxt == ST_RUN);
    fail_nxt   = fail_r || go_fail;
    tot_nxt    = tot_r || (go_fail && tot_fail_det);
    def_nxt    = def_r || (go_fail && defect_det);
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r  <= ST_START;
      rng_ok_r <= 1'b0;
      fail_r   <= 1'b0;
      tot_r    <= 1'b0;
      def_r    <= 1'b0;
    end
    else
    begin
      state_r  <= state_nxt;
      rng_ok_r <= rng_ok_nxt;
      fail_r   <= fail_nxt;
      tot_r    <= tot_nxt;
      def_r    <= def_nxt;
    end
  end

  // delay line and word assembly
  logic [DLY_LEN-1:0] dly_r;
  logic [RUN_W-1:0]   dly_cnt_r;
  logic [WORD_W-1:0]  asm_r;
  logic [CNT_W-1:0]   asm_cnt_r;
  logic               asm_w16_r;
  logic               asm_full_r;
  logic [DLY_LEN-1:0] dly_nxt;
  logic [RUN_W-1:0]   dly_cnt_nxt;
  logic [WORD_W-1:0]  asm_nxt;
  logic [CNT_W-1:0]   asm_cnt_nxt;
  logic               asm_w16_nxt;
  logic               asm_full_nxt;
  logic               use_bit;    // delayed bit joins the word
  logic               w16;        // width of the word in progress
  logic               fifo_wr_valid;
  logic               fifo_wr_ready;

  assign w16 = (asm_cnt_r == '0) ? wide16 : asm_w16_r;
  assign use_bit = smp_tick && (dly_cnt_r == DLY_LEN[RUN_W-1:0]) &&
                   !asm_full_r && (state_r == ST_RUN) && !go_fail;
  assign fifo_wr_valid = asm_full_r && (state_r == ST_RUN) && !go_fail;

  // a bit leaves the delay only after 48 later bits passed the
  // stuck test; bits arriving while the buffer is full are lost
  always_comb
  begin
    dly_nxt      = dly_r;
    dly_cnt_nxt  = dly_cnt_r;
    asm_nxt      = asm_r;
    asm_cnt_nxt  = asm_cnt_r;
    asm_w16_nxt  = asm_w16_r;
    asm_full_nxt = asm_full_r;
    if (smp_tick)
    begin
      dly_nxt = {dly_r[DLY_LEN-2:0], raw_s2_r};
      if (dly_cnt_r != DLY_LEN[RUN_W-1:0])
        dly_cnt_nxt = dly_cnt_r + 1'b1;
    end
    if ((state_r != ST_RUN) || go_fail)
    begin
      // partial word is discarded on any failure
      asm_nxt      = '0;
      asm_cnt_nxt  = '0;
      asm_full_nxt = 1'b0;
    end
    else if (fifo_wr_valid && fifo_wr_ready)
    begin
      asm_nxt      = '0;
      asm_cnt_nxt  = '0;
      asm_full_nxt = 1'b0;
    end
    else if (use_bit)
    begin
      asm_nxt      = {asm_r[WORD_W-2:0], dly_r[DLY_LEN-1]};
      asm_cnt_nxt  = asm_cnt_r + 1'b1;
      asm_w16_nxt  = w16;
      asm_full_nxt = (asm_cnt_nxt == (w16 ? BITS_16 : BITS_8));
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dly_r      <= '0;
      dly_cnt_r  <= '0;
      asm_r      <= '0;
      asm_cnt_r  <= '0;
      asm_w16_r  <= 1'b0;
      asm_full_r <= 1'b0;
    end
    else
    begin
      dly_r      <= dly_nxt;
      dly_cnt_r  <= dly_cnt_nxt;
      asm_r      <= asm_nxt;
      asm_cnt_r  <= asm_cnt_nxt;
      asm_w16_r  <= asm_w16_nxt;
      asm_full_r <= asm_full_nxt;
    end
  end

  // word buffer, flushed on failure
  logic              fifo_rd_valid;
  logic              fifo_rd_ready;
  logic [WORD_W-1:0] fifo_rd_data;

  trng_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock    (clock),
    .rst_n    (rst_n),
    .flush    (go_fail),
    .wr_valid (fifo_wr_valid),
    .wr_ready (fifo_wr_ready),
    .wr_data  (asm_r),
    .rd_valid (fifo_rd_valid),
    .rd_ready (fifo_rd_ready),
    .rd_data  (fifo_rd_data)
  );

  // registered output stage
  logic              out_valid_r;
  logic [WORD_W-1:0] out_data_r;
  logic              out_valid_nxt;
  logic [WORD_W-1:0] out_data_nxt;

  assign fifo_rd_ready = (state_r == ST_RUN) && !go_fail &&
                         (!out_valid_r || out_ready);

  // a held word is dropped, not delivered, once a failure shows
  always_comb
  begin
    out_valid_nxt = out_valid_r;
    out_data_nxt  = out_data_r;
    if ((state_r != ST_RUN) || go_fail)
    begin
      out_valid_nxt = 1'b0;
      out_data_nxt  = '0;
    end
    else if (fifo_rd_ready && fifo_rd_valid)
    begin
      out_valid_nxt = 1'b1;
      out_data_nxt  = fifo_rd_data;
    end
    else if (out_ready)
      out_valid_nxt = 1'b0;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out_valid_r <= 1'b0;
      out_data_r  <= '0;
    end
    else
    begin
      out_valid_r <= out_valid_nxt;
      out_data_r  <= out_data_nxt;
    end
  end

  assign out_valid   = out_valid_r;
  assign out_data    = out_data_r;
  assign rng_ok      = rng_ok_r;
  assign fail_sticky = fail_r;
  assign fail_total  = tot_r;
  assign fail_defect = def_r;

  // cycles since the last window closed; one window span is too
  // long for a delay range, so the bound is checked on a count
  localparam int unsigned WIN_CYC = SAMPLE_CYC << WIN_W;
  logic [WIN_W+SMP_W:0] win_age_r;
  logic [WIN_W+SMP_W:0] win_age_nxt;

  // helper only; it could wrap, but the check trips long before
  always_comb
  begin
    win_age_nxt = win_end ? '0 : win_age_r + 1'b1;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      win_age_r <= '0;
    else
      win_age_r <= win_age_nxt;
  end

  // checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  sequence s_failure;
    tot_fail_det || defect_det;
  endsequence

  sequence s_blocked;
    !out_valid_r && !rng_ok_r && fail_r;
  endsequence

  a_fail_blocks: assert property (s_failure |=> s_blocked)
    else $error("output not blocked after failure");
  a_valid_needs_ok: assert property (out_valid_r |-> rng_ok_r)
    else $error("word delivered while gate closed");
  a_no_early_out: assert property (state_r == ST_START |-> !out_valid_r &&
                  !fifo_wr_valid)
    else $error("word delivered before startup test");
  a_ok_after_window: assert property ($rose(rng_ok_r) |-> $past(win_end)
                     && !fail_r)
    else $error("service began without a passed window");
  a_fail_sticky: assert property (fail_r |=> fail_r && !rng_ok_r)
    else $error("failure flag cleared");
  a_sample_period: assert property (smp_tick |=> !smp_tick [*7] ##1
                   smp_tick)
    else $error("raw sampling not periodic");
  a_window_bound: assert property (win_age_r < WIN_CYC[WIN_W+SMP_W:0])
    else $error("online test window overran");
  a_byte_word: assert property (fifo_wr_valid && !asm_w16_r |->
               asm_r[15:8] == 8'h00 && asm_cnt_r == BITS_8)
    else $error("8-bit word malformed");
  a_stuck_caught: assert property (run_cnt_r == TOT_RUN_LIMIT |->
                  state_r == ST_FAIL)
    else $error("stuck source not caught");

endmodule

// *** verification/word_consumer.sv ***
// consumer on the word port: takes words, may stall, judges each word
module word_consumer
  import trng_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              stall,
  input  wire logic              chk_val,
  input  wire logic              fail_sticky,
  input  wire logic              out_valid,
  input  wire logic [WORD_W-1:0] out_data,
  output logic                   out_ready,
  output int                     n_taken,
  output int                     n_bad,
  output logic      [WORD_W-1:0] last_word
);
  timeunit 1ns;
  timeprecision 1ps;

  logic              fail_d;  // failure flag one edge late, a grace cycle
  logic              wait_d;  // a word was offered and not taken
  logic [WORD_W-1:0] held;    // the word that must stand
  int                bad;     // faults found at this edge

  // an alternating source only ever yields these four words
  function automatic logic good(input logic [WORD_W-1:0] d);
    return d === 16'haaaa || d === 16'h5555 ||
           d === 16'h00aa || d === 16'h0055;
  endfunction

  initial
  begin
    out_ready = 1'b0;
    n_taken   = 0;
    n_bad     = 0;
    last_word = '0;
    fail_d    = 1'b0;
    wait_d    = 1'b0;
    held      = '0;
  end

  // ready follows stall one edge later, like a real slow reader
  always @(posedge clock)
  begin
    bad = 0;
    if (out_valid === 1'b1 && out_ready === 1'b1)
    begin
      n_taken   <= n_taken + 1;
      last_word <= out_data;
      if (fail_d === 1'b1)
        bad++;
      else if (chk_val === 1'b1 && !good(out_data))
        bad++;
    end
    // an offered word stands until taken or withdrawn
    if (wait_d && out_valid === 1'b1 && out_data !== held)
      bad++;
    if (bad > 0)
      $display("ERROR at %0t: bad word %h", $time, out_data);
    n_bad     <= n_bad + bad;
    wait_d    <= out_valid === 1'b1 && out_ready !== 1'b1;
    held      <= out_data;
    fail_d    <= fail_sticky;
    out_ready <= !stall;
  end
endmodule

// *** verification/physical_trng_health_gate_tb.sv ***
module physical_trng_health_gate_tb
  import trng_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic              clock;
  logic              resetn;
  logic              raw_bit;
  logic              wide16;
  logic              out_ready;
  logic [WORD_W-1:0] out_data;
  logic              out_valid;
  logic              rng_ok;
  logic              fail_sticky;
  logic              fail_total;
  logic              fail_defect;
  logic              stall;
  logic              chk_val;
  logic [1:0]        mode;     // 0 alternate, 1 stuck 1, 2 stuck 0, 3 biased
  logic [5:0]        slot;     // free counter that paces the source
  int                n_taken;
  int                n_bad;
  logic [WORD_W-1:0] last_word;
  int                fails;
  int                n_compared;
  int                base;

  physical_trng_health_gate i_dut (
    .clock       (clock),
    .resetn      (resetn),
    .raw_bit     (raw_bit),
    .wide16      (wide16),
    .out_ready   (out_ready),
    .out_data    (out_data),
    .out_valid   (out_valid),
    .rng_ok      (rng_ok),
    .fail_sticky (fail_sticky),
    .fail_total  (fail_total),
    .fail_defect (fail_defect)
  );

  word_consumer i_cons (
    .clock       (clock),
    .stall       (stall),
    .chk_val     (chk_val),
    .fail_sticky (fail_sticky),
    .out_valid   (out_valid),
    .out_data    (out_data),
    .out_ready   (out_ready),
    .n_taken     (n_taken),
    .n_bad       (n_bad),
    .last_word   (last_word)
  );

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // source holds each value 8 clocks so every sample sees one slot
  always @(posedge clock)
  begin
    slot <= slot + 6'h01;
    case (mode)
      2'h0:    raw_bit <= slot[3];
      2'h1:    raw_bit <= 1'b1;
      2'h2:    raw_bit <= 1'b0;
      default: raw_bit <= slot[5:3] == 3'h0; // 1 in 8: biased, no long run
    endcase
  end

  task automatic check(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'b1)
    begin
      fails++;
      $display("ERROR at %0t: %s", $time, msg);
    end
  endtask

  function automatic logic sel(input int k);
    case (k)
      0:       return rng_ok;
      1:       return fail_total;
      2:       return fail_defect;
      default: return ~out_valid;
    endcase
  endfunction

  // bounded wait on a design flag
  task automatic wait_until(input int k, input int lim, input string what);
    int i;
    i = 0;
    while (sel(k) !== 1'b1 && i < lim)
    begin
      @(posedge clock);
      #1;
      i++;
    end
    check(sel(k) === 1'b1, what);
  endtask

  task automatic wait_words(input int n);
    int i;
    i = n_taken + n;
    repeat (128 * n + 300)
      if (n_taken < i)
        @(posedge clock);
    #1;
    check(n_taken >= i, "words missing");
  endtask

  task automatic do_reset(input logic [1:0] m);
    @(posedge clock);
    resetn <= 1'b0;
    mode   <= m;
    repeat (6) @(posedge clock);
    #1;
    check(out_valid === 1'b0 && fail_sticky === 1'b0, "reset state");
    @(posedge clock);
    resetn <= 1'b1;
  endtask

  task automatic t_startup();
    do_reset(2'h0);
    repeat (1500) @(posedge clock);
    #1;
    check(rng_ok === 1'b0 && n_taken === 0, "output before startup");
    wait_until(0, 1000, "gate never opened");
    wait_words(2);
    $display("test startup done");
  endtask

  task automatic t_widths();
    @(posedge clock);
    wide16 <= 1'b0;
    wait_words(3);
    check(last_word[15:8] === 8'h00, "8-bit word too wide");
    @(posedge clock);
    wide16 <= 1'b1;
    wait_words(3);
    check(last_word[15:8] !== 8'h00, "16-bit word too narrow");
    $display("test widths done");
  endtask

  task automatic t_fill_drain();
    @(posedge clock);
    stall <= 1'b1;
    repeat (2800) @(posedge clock);
    #1;
    check(out_valid === 1'b1, "word not standing");
    base = n_taken;
    @(posedge clock);
    stall <= 1'b0;
    repeat (30) @(posedge clock);
    #1;
    check(n_taken - base >= FIFO_DEPTH, "buffer not full");
    wait_until(3, 300, "buffer never empty");
    $display("test fill_drain done");
  endtask

  task automatic t_stuck_run();
    @(posedge clock);
    mode <= 2'h1;
    wait_until(1, 48 * 8 + 300, "stuck source unseen");
    base = n_taken;
    @(posedge clock);
    mode <= 2'h0;
    repeat (3000) @(posedge clock);
    #1;
    check(fail_sticky === 1'b1 && rng_ok === 1'b0, "flag not sticky");
    check(n_taken === base, "word after failure");
    $display("test stuck_run done");
  endtask

  task automatic t_start_stuck();
    do_reset(2'h2);
    wait_until(1, 48 * 8 + 300, "startup stuck unseen");
    repeat (2500) @(posedge clock);
    #1;
    check(rng_ok === 1'b0 && n_taken === base, "output after failure");
    $display("test start_stuck done");
  endtask

  task automatic t_start_defect();
    chk_val <= 1'b0;
    do_reset(2'h3);
    wait_until(2, 2400, "startup defect unseen");
    repeat (500) @(posedge clock);
    #1;
    check(fail_total === 1'b0 && n_taken === base, "defect gate");
    $display("test start_defect done");
  endtask

  task automatic t_run_defect();
    do_reset(2'h0);
    wait_until(0, 2600, "gate never opened");
    @(posedge clock);
    mode <= 2'h3;
    wait_until(2, 4400, "running defect unseen");
    repeat (2) @(posedge clock);
    #1;
    check(rng_ok === 1'b0 && out_valid === 1'b0, "gate left open");
    $display("test run_defect done");
  endtask

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    resetn     = 1'b0;
    raw_bit    = 1'b0;
    wide16     = 1'b1;
    stall      = 1'b0;
    chk_val    = 1'b1;
    mode       = 2'h0;
    slot       = 6'h00;
    fails      = 0;
    n_compared = 0;
    base       = 0;
    t_startup();
    t_widths();
    t_fill_drain();
    t_stuck_run();
    t_start_stuck();
    t_start_defect();
    t_run_defect();
    check(n_bad === 0, "consumer saw bad words");
    give_verdict();
  end

  // cut a hang short well beyond the planned run
  initial
  begin
    repeat (40000) @(posedge clock);
    fails++;
    $display("ERROR at %0t: watchdog expired", $time);
    give_verdict();
  end
endmodule
